// ==== rtl/btm_defines.svh ====
// constants for the bus throughput and delay monitor
// assumes inclusion by the package, the monitor end and the bench
`ifndef BTM_DEFINES_SVH
`define BTM_DEFINES_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BTM_OFF_CTRL 12'h000
`define BTM_OFF_STATUS 12'h004
`define BTM_OFF_CYC_LO 12'h010
`define BTM_OFF_CYC_HI 12'h014
`define BTM_OFF_RDB_LO 12'h018
`define BTM_OFF_RDB_HI 12'h01c
`define BTM_OFF_WRB_LO 12'h020
`define BTM_OFF_WRB_HI 12'h024
`define BTM_OFF_RDREQ_LO 12'h028
`define BTM_OFF_RDREQ_HI 12'h02c
`define BTM_OFF_WRREQ_LO 12'h030
`define BTM_OFF_WRREQ_HI 12'h034
`define BTM_OFF_WRRSP_LO 12'h038
`define BTM_OFF_WRRSP_HI 12'h03c
`define BTM_OFF_DELAY 12'h040
// ****************************************
// control fields
// ****************************************
`define BTM_CTRL_START 0
`define BTM_CTRL_STOP 1
`define BTM_CTRL_WIDE 2
`define BTM_CTRL_SLOT_LSB 4
`define BTM_CTRL_RESET 32'h0000_0000
// ****************************************
// link shape
// ****************************************
`define BTM_SLOTS 4
`define BTM_DATA_W 64
`define BTM_STRB_W 8
`define BTM_LEN_W 8
`endif

// ==== rtl/btm_pkg.sv ====
// types for the bus throughput and delay monitor
// assumes btm_defines.svh is on the include path
package btm_pkg;
	`include "btm_defines.svh"
	// monitor command state
	typedef enum logic [2:0] {
		BTM_IDLE = 3'b001,
		BTM_RUN = 3'b010,
		BTM_HELD = 3'b100
	} btm_state_e;
	// one event counter
	typedef logic [63:0] btm_cnt_t;
endpackage

// ==== rtl/btm_if.sv ====
// interface joining the monitor and its controller
// assumes a shared pclk/presetn and one observed link per slot
`timescale 1ns/1ns
interface btm_if
	import btm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn
);
	// ****************************************
	// register port
	// ****************************************
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	// ****************************************
	// video markers routed in by the integrator
	// ****************************************
	logic source_frame_sync;
	logic display_vsync;
	modport mon
	(
		input pclk, presetn, paddr, psel, penable, pwrite, pwdata,
		input source_frame_sync, display_vsync,
		output pready, pslverr, prdata
	);
	modport ctl
	(
		input pclk, presetn, pready, pslverr, prdata,
		output paddr, psel, penable, pwrite, pwdata, source_frame_sync, display_vsync
	);
endinterface

// ==== rtl/btm_monitor.sv ====
// passive throughput and frame delay monitor, device end
// assumes pclk is the faster link clock and all inputs are synchronous to it
//
// Overview of operation
// - observe only read and write channels
// - never alter, delay or inject transactions
// - four slots; integrator attaches memory link
// - core clock is faster bus clock
// - count bytes, requests and write responses
// - count only between software start and end
// - cycle counter spans start to end
// - counter width selectable, 32 or 64
// - final metrics readable over register port
// - count only completed handshakes, strobes qualified
// - measure frame delay in clock cycles
// - frame sync starts, display vsync ends
// - integrator connects video signals
// - all registers behind the register slave
`timescale 1ns/1ns
`include "btm_defines.svh"
module btm_monitor
	import btm_pkg::*;
(
	btm_if.mon bus,
	input wire logic [`BTM_SLOTS-1:0] arvalid,
	input wire logic [`BTM_SLOTS-1:0] arready,
	input wire logic [`BTM_SLOTS*`BTM_LEN_W-1:0] arlen,
	input wire logic [`BTM_SLOTS-1:0] rvalid,
	input wire logic [`BTM_SLOTS-1:0] rready,
	input wire logic [`BTM_SLOTS-1:0] awvalid,
	input wire logic [`BTM_SLOTS-1:0] awready,
	input wire logic [`BTM_SLOTS-1:0] wvalid,
	input wire logic [`BTM_SLOTS-1:0] wready,
	input wire logic [`BTM_SLOTS*`BTM_STRB_W-1:0] wstrb,
	input wire logic [`BTM_SLOTS-1:0] bvalid,
	input wire logic [`BTM_SLOTS-1:0] bready,
	output logic running,
	output logic delay_valid
);
	// ****************************************
	// helpers
	// ****************************************
	// number of set strobe bits, i.e. bytes in one beat
	function automatic logic [3:0] strb_bytes(input logic [`BTM_STRB_W-1:0] s);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < `BTM_STRB_W; i++)
		begin
			n = n + {3'h0, s[i]};
		end
		return n;
	endfunction
	// counter step honouring the selected width
	function automatic btm_cnt_t bump(input btm_cnt_t c, input btm_cnt_t d, input logic wide);
		btm_cnt_t s;
		s = c + d;
		return wide ? s : {32'h0, s[31:0]};
	endfunction
	// ****************************************
	// state and registers
	// ****************************************
	btm_state_e state_reg; // run state
	logic wide_reg; // 64-bit counters when set
	logic [1:0] slot_reg; // slot under observation
	btm_cnt_t cyc_reg; // elapsed cycles
	btm_cnt_t rdb_reg; // bytes read
	btm_cnt_t wrb_reg; // bytes written
	btm_cnt_t rdreq_reg; // read requests
	btm_cnt_t wrreq_reg; // write requests
	btm_cnt_t wrrsp_reg; // write responses
	logic [31:0] dly_cnt_reg; // running frame delay count
	logic [31:0] dly_reg; // last finished delay
	logic dly_busy_reg; // waiting for display vsync
	logic fs_d_reg; // previous frame sync
	logic vs_d_reg; // previous vsync
	logic [31:0] prdata_reg; // read data
	logic pready_reg; // access answer
	logic pslverr_reg; // unmapped answer
	logic wr_go; // write phase of access
	logic start_cmd; // software start
	logic stop_cmd; // software end
	logic cnt_en; // counting window
	// one wait state: pready rises the cycle after access is seen
	assign wr_go = bus.psel && bus.penable && bus.pwrite && !pready_reg;
	assign start_cmd = wr_go && bus.paddr == `BTM_OFF_CTRL && bus.pwdata[`BTM_CTRL_START];
	assign stop_cmd = wr_go && bus.paddr == `BTM_OFF_CTRL && bus.pwdata[`BTM_CTRL_STOP];
	assign cnt_en = state_reg == BTM_RUN;
	// ****************************************
	// run control
	// ****************************************
	// start wins if both bits are written together
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
			state_reg <= BTM_IDLE;
		else if (start_cmd)
			state_reg <= BTM_RUN;
		else if (stop_cmd && state_reg == BTM_RUN)
			state_reg <= BTM_HELD;
	end
	// configuration, ignored while counting so width cannot change mid run
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			wide_reg <= 1'b0;
			slot_reg <= 2'h0;
		end
		else if (wr_go && bus.paddr == `BTM_OFF_CTRL && !cnt_en)
		begin
			wide_reg <= bus.pwdata[`BTM_CTRL_WIDE];
			slot_reg <= bus.pwdata[`BTM_CTRL_SLOT_LSB +: 2];
		end
	end
	// ****************************************
	// event counters, inputs are only read
	// ****************************************
	// nothing is driven back onto the observed link
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			cyc_reg <= 64'h0;
			rdb_reg <= 64'h0;
			wrb_reg <= 64'h0;
			rdreq_reg <= 64'h0;
			wrreq_reg <= 64'h0;
			wrrsp_reg <= 64'h0;
		end
		else if (start_cmd)
		begin
			cyc_reg <= 64'h0;
			rdb_reg <= 64'h0;
			wrb_reg <= 64'h0;
			rdreq_reg <= 64'h0;
			wrreq_reg <= 64'h0;
			wrrsp_reg <= 64'h0;
		end
		else if (cnt_en)
		begin
			cyc_reg <= bump(cyc_reg, 64'h1, wide_reg);
			if (arvalid[slot_reg] && arready[slot_reg])
				rdreq_reg <= bump(rdreq_reg, 64'h1, wide_reg);
			if (rvalid[slot_reg] && rready[slot_reg])
				rdb_reg <= bump(rdb_reg, 64'(`BTM_STRB_W), wide_reg);
			if (awvalid[slot_reg] && awready[slot_reg])
				wrreq_reg <= bump(wrreq_reg, 64'h1, wide_reg);
			if (wvalid[slot_reg] && wready[slot_reg])
				wrb_reg <= bump(wrb_reg, {60'h0, strb_bytes(wstrb[slot_reg*`BTM_STRB_W +: `BTM_STRB_W])}, wide_reg);
			if (bvalid[slot_reg] && bready[slot_reg])
				wrrsp_reg <= bump(wrrsp_reg, 64'h1, wide_reg);
		end
	end
	// ****************************************
	// frame delay
	// ****************************************
	// rising frame sync opens, rising vsync closes; a new sync restarts
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			fs_d_reg <= 1'b0;
			vs_d_reg <= 1'b0;
			dly_busy_reg <= 1'b0;
			dly_cnt_reg <= 32'h0;
			dly_reg <= 32'h0;
			delay_valid <= 1'b0;
		end
		else
		begin
			fs_d_reg <= bus.source_frame_sync;
			vs_d_reg <= bus.display_vsync;
			if (bus.source_frame_sync && !fs_d_reg)
			begin
				dly_busy_reg <= 1'b1;
				dly_cnt_reg <= 32'h1;
			end
			else if (dly_busy_reg && bus.display_vsync && !vs_d_reg)
			begin
				dly_busy_reg <= 1'b0;
				dly_reg <= dly_cnt_reg;
				delay_valid <= 1'b1;
			end
			else if (dly_busy_reg)
				dly_cnt_reg <= dly_cnt_reg + 32'h1;
		end
	end
	// ****************************************
	// register slave
	// ****************************************
	// read mux, high halves read zero in 32-bit mode by construction
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else if (bus.psel && bus.penable && !pready_reg)
		begin
			pready_reg <= 1'b1;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
			case (bus.paddr)
				`BTM_OFF_CTRL: prdata_reg <= {26'h0, slot_reg, 1'b0, wide_reg, 2'h0};
				`BTM_OFF_STATUS: prdata_reg <= {29'h0, state_reg};
				`BTM_OFF_CYC_LO: prdata_reg <= cyc_reg[31:0];
				`BTM_OFF_CYC_HI: prdata_reg <= cyc_reg[63:32];
				`BTM_OFF_RDB_LO: prdata_reg <= rdb_reg[31:0];
				`BTM_OFF_RDB_HI: prdata_reg <= rdb_reg[63:32];
				`BTM_OFF_WRB_LO: prdata_reg <= wrb_reg[31:0];
				`BTM_OFF_WRB_HI: prdata_reg <= wrb_reg[63:32];
				`BTM_OFF_RDREQ_LO: prdata_reg <= rdreq_reg[31:0];
				`BTM_OFF_RDREQ_HI: prdata_reg <= rdreq_reg[63:32];
				`BTM_OFF_WRREQ_LO: prdata_reg <= wrreq_reg[31:0];
				`BTM_OFF_WRREQ_HI: prdata_reg <= wrreq_reg[63:32];
				`BTM_OFF_WRRSP_LO: prdata_reg <= wrrsp_reg[31:0];
				`BTM_OFF_WRRSP_HI: prdata_reg <= wrrsp_reg[63:32];
				`BTM_OFF_DELAY: prdata_reg <= dly_reg;
				default: pslverr_reg <= 1'b1; // unmapped
			endcase
		end
		else
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end
	// status pin mirrors run state
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
			running <= 1'b0;
		else
			running <= cnt_en;
	end
	assign bus.pready = pready_reg;
	assign bus.pslverr = pslverr_reg;
	assign bus.prdata = prdata_reg;
endmodule

// ==== rtl/btm_ctrl.sv ====
// controller end: turns user orders into register accesses
// assumes the monitor answers every access within a few cycles
`timescale 1ns/1ns
module btm_ctrl
	import btm_pkg::*;
(
	btm_if.ctl bus,
	input wire logic req,
	input wire logic req_write,
	input wire logic [11:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic frame_sync_in,
	input wire logic vsync_in,
	output logic busy,
	output logic done,
	output logic [31:0] rdata,
	output logic err
);
	// ****************************************
	// bus master
	// ****************************************
	logic [11:0] paddr_reg; // held address
	logic psel_reg; // select
	logic penable_reg; // access phase
	logic pwrite_reg; // direction
	logic [31:0] pwdata_reg; // write data
	logic fs_reg; // routed frame sync
	logic vs_reg; // routed vsync
	// one transfer at a time; req ignored while busy
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			paddr_reg <= 12'h0;
			psel_reg <= 1'b0;
			penable_reg <= 1'b0;
			pwrite_reg <= 1'b0;
			pwdata_reg <= 32'h0;
			busy <= 1'b0;
			done <= 1'b0;
			rdata <= 32'h0;
			err <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!psel_reg && req)
			begin
				psel_reg <= 1'b1; // setup cycle
				paddr_reg <= req_addr;
				pwrite_reg <= req_write;
				pwdata_reg <= req_wdata;
				busy <= 1'b1;
			end
			else if (psel_reg && !penable_reg)
				penable_reg <= 1'b1; // access phase
			else if (psel_reg && bus.pready)
			begin
				psel_reg <= 1'b0;
				penable_reg <= 1'b0;
				busy <= 1'b0;
				done <= 1'b1;
				err <= bus.pslverr;
				if (!pwrite_reg)
					rdata <= bus.prdata;
			end
		end
	end
	// video markers are registered straight through
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			fs_reg <= 1'b0;
			vs_reg <= 1'b0;
		end
		else
		begin
			fs_reg <= frame_sync_in;
			vs_reg <= vsync_in;
		end
	end
	assign bus.paddr = paddr_reg;
	assign bus.psel = psel_reg;
	assign bus.penable = penable_reg;
	assign bus.pwrite = pwrite_reg;
	assign bus.pwdata = pwdata_reg;
	assign bus.source_frame_sync = fs_reg;
	assign bus.display_vsync = vs_reg;
endmodule

// ==== bench/btm_asserts.sv ====
// checker for the register port joining controller and monitor
// assumes one clock domain; tb_top instantiates it on the interface
`timescale 1ns/1ns
module btm_asserts
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata
);
	// ****************
	// common clock and reset
	// ****************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// setup cycle, then first access cycle
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_first_access;
		s_setup ##1 (psel && penable);
	endsequence
	// one wait state, never more or less
	property p_wait_state;
		s_first_access |-> !pready ##1 pready;
	endproperty
	a_wait_state: assert property (p_wait_state)
		else $error("answer not after one wait state");
	property p_setup_first;
		$rose(penable) |-> $past(psel) && !$past(penable);
	endproperty
	a_setup_first: assert property (p_setup_first)
		else $error("access without setup");
	property p_enable_in_select;
		penable |-> psel;
	endproperty
	a_enable_in_select: assert property (p_enable_in_select)
		else $error("enable without select");
	// request held until answered
	property p_hold;
		psel && penable && !pready |=> psel && penable && $stable(paddr) && $stable(pwrite) && $stable(pwdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request changed before answer");
	property p_ready_pulse;
		pready |=> !pready && !penable;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("answer or access too long");
	property p_err_in_answer;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_in_answer: assert property (p_err_in_answer)
		else $error("error outside answer");
	// nothing lives above the delay word
	property p_unmapped;
		pready && paddr > 12'h040 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_err_zero;
		pslverr && !pwrite |-> prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("refused read returned data");
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench: controller and monitor joined by the interface
// assumes the design files are compiled first
`timescale 1ns/1ns
`include "btm_defines.svh"
module tb_top;
	// ****************
	// stimulus and results
	// ****************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic [11:0] req_addr = 12'h000;
	logic [31:0] req_wdata = 32'h0;
	logic frame_sync_in = 1'b0;
	logic vsync_in = 1'b0;
	logic [3:0] arvalid, arready, rvalid, rready, awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0] wstrb = 32'h0;
	logic busy, done, err, running, delay_valid;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h31; // lfsr state
	int cnt [5]; // rd bytes, wr bytes, rd req, wr req, wr resp
	int n_fail = 0;
	int comparisons = 0;
	int n_edge = 0; // clock edges seen so far
	int t0; // edge count when the start order is issued
	int t1; // edge count when the stop order is issued
	typedef struct {logic rd; logic [31:0] d; logic e;} btm_exp_s;
	btm_exp_s expq [$]; // notes of the driver, oldest first
	btm_exp_s e;
	always #5 pclk = ~pclk;
	// edge counter, updated late so every reader at an edge sees the same value
	always @(posedge pclk)
		n_edge <= n_edge + 1;
	btm_if btm_if_inst (.pclk(pclk), .presetn(presetn));
	btm_monitor btm_monitor_inst (.bus(btm_if_inst.mon), .arvalid(arvalid), .arready(arready), .arlen(32'h0),
		.rvalid(rvalid), .rready(rready), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
		.wready(wready), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .running(running),
		.delay_valid(delay_valid));
	btm_ctrl btm_ctrl_inst (.bus(btm_if_inst.ctl), .req(req), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .frame_sync_in(frame_sync_in), .vsync_in(vsync_in), .busy(busy),
		.done(done), .rdata(rdata), .err(err));
	btm_asserts btm_asserts_inst (.pclk(pclk), .presetn(presetn), .paddr(btm_if_inst.paddr),
		.psel(btm_if_inst.psel), .penable(btm_if_inst.penable), .pwrite(btm_if_inst.pwrite),
		.pwdata(btm_if_inst.pwdata), .pready(btm_if_inst.pready), .pslverr(btm_if_inst.pslverr),
		.prdata(btm_if_inst.prdata));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic stop_test();
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	// one register access; the watcher compares the answer
	task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d, input logic x);
		int k;
		expq.push_back('{!w, d, x});
		req <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
		chk("busy", 32'h1, {31'h0, busy});
		for (k = 0; k < 40 && done !== 1'b1; k++)
			@(posedge pclk);
		if (k == 40)
		begin
			chk("done", 32'h1, 32'h0);
			stop_test();
		end
	endtask
	// random link traffic on all slots; only slot s is expected
	task automatic traffic(input int s, input int n, input logic on);
		logic [31:0] r;
		logic [31:0] b; // response channel bits
		repeat (n)
		begin
			r = lfsr(seed);
			seed = lfsr(lfsr(r));
			{arvalid, arready, rvalid, rready, awvalid, awready, wvalid, wready} <= r;
			b = lfsr(r);
			{bvalid, bready} <= b[7:0];
			wstrb <= seed;
			if (on && r[20+s] && r[16+s])
				cnt[0] += 8;
			if (on && r[4+s] && r[s])
				cnt[1] += $countones(seed[8*s+:8]);
			cnt[2] += int'(on && r[28+s] && r[24+s]);
			cnt[3] += int'(on && r[12+s] && r[8+s]);
			cnt[4] += int'(on && b[4+s] && b[s]);
			@(posedge pclk);
		end
		{arvalid, arready, rvalid, rready, awvalid, awready, wvalid, wready, bvalid, bready} <= '0;
	endtask
	// watcher: oldest note against each finished transfer
	always @(posedge pclk)
	begin
		if (done === 1'b1)
		begin
			e = expq.pop_front();
			chk("err", {31'h0, e.e}, {31'h0, err});
			if (e.rd)
				chk("rdata", e.d, rdata);
		end
	end
	// ****************
	// main sequence
	// ****************
	initial
	begin
		{arvalid, arready, rvalid, rready, awvalid, awready, wvalid, wready, bvalid, bready} <= '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		op(0, `BTM_OFF_STATUS, 32'h1, 0);
		op(0, `BTM_OFF_CTRL, `BTM_CTRL_RESET, 0);
		op(0, 12'h100, 32'h0, 1);
		op(1, 12'h008, 32'hffff_ffff, 1);
		// slot 1 wide, then slot 2 narrow; second start must clear
		for (int p = 0; p < 2; p++)
		begin
			cnt = '{default: 0};
			t0 = n_edge;
			op(1, `BTM_OFF_CTRL, 32'h1 | ((p + 1) << `BTM_CTRL_SLOT_LSB) | ((1 - p) << `BTM_CTRL_WIDE), 0);
			chk("running", 32'h1, {31'h0, running});
			op(1, `BTM_OFF_CTRL, 32'h34, 0);
			op(0, `BTM_OFF_STATUS, 32'h2, 0);
			traffic(p + 1, 60, 1);
			t1 = n_edge;
			op(1, `BTM_OFF_CTRL, 32'h1 << `BTM_CTRL_STOP, 0);
			chk("running", 32'h0, {31'h0, running});
			traffic(p + 1, 20, 0);
			op(0, `BTM_OFF_STATUS, 32'h4, 0);
			for (int i = 0; i < 5; i++)
			begin
				op(0, 12'(`BTM_OFF_RDB_LO + 8 * i), cnt[i], 0);
				op(0, 12'(`BTM_OFF_RDB_LO + 8 * i + 4), 32'h0, 0);
			end
			// start and stop take effect equally late, so the gap between calls is the count
			op(0, `BTM_OFF_CYC_LO, 32'(t1 - t0), 0);
			op(0, `BTM_OFF_CYC_HI, 32'h0, 0);
		end
		// frame delay of 7 cycles
		chk("delay_valid", 32'h0, {31'h0, delay_valid});
		frame_sync_in <= 1'b1;
		repeat (7) @(posedge pclk);
		vsync_in <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("delay_valid", 32'h1, {31'h0, delay_valid});
		op(0, `BTM_OFF_DELAY, 32'h7, 0);
		@(posedge pclk);
		stop_test();
	end
endmodule
